// file: hdl/drp_params.svh
`ifndef DRP_PARAMS_SVH
`define DRP_PARAMS_SVH

// ****************************************
// register bus
// ****************************************
`define DRP_ADDR_W 8
`define DRP_DATA_W 16
`define DRP_OFS_CTRL 8'h00
`define DRP_OFS_STATUS 8'h04
`define DRP_OFS_FIFO_DATA 8'h08
`define DRP_OFS_TEST_WORD 8'h0C
`define DRP_OFS_TEST_PULSES 8'h10

// ****************************************
// command bits of the control register
// ****************************************
`define DRP_CMD_W 7
`define DRP_CMD_START 0
`define DRP_CMD_CLEAR 1
`define DRP_CMD_TEST_SET 2
`define DRP_CMD_TEST_CLR 3
`define DRP_CMD_WRITE_CLR 4
`define DRP_CMD_WRITE_SET 5
`define DRP_CMD_RATE_ACK 6

// ****************************************
// status bits of the status register
// ****************************************
`define DRP_STAT_W 7
`define DRP_STAT_STARTED 0
`define DRP_STAT_LOOPBACK 1
`define DRP_STAT_READ_ACTIVE 2
`define DRP_STAT_FIFO_AVAIL 3
`define DRP_STAT_CRC_ERROR 4
`define DRP_STAT_RATE_ERROR 5
`define DRP_STAT_LOAD_AVAIL 6

// ****************************************
// stream format and reset values
// ****************************************
`define DRP_SYNC_WORD 16'h00FF
`define DRP_CRC_POLY 16'h1021
`define DRP_CRC_INIT 16'hFFFF
`define DRP_TEST_WORD_RESET 16'h0000
`define DRP_WORD_BITS 16
`define DRP_FIFO_DEPTH 16
`define DRP_SLICE_W 4

// ****************************************
// timing
// ****************************************
`define DRP_CLK_PERIOD_NS 20
`define DRP_TEST_PHASE_NS 600
`define DRP_TEST_PHASE_CYC ((`DRP_TEST_PHASE_NS + `DRP_CLK_PERIOD_NS - 1) / `DRP_CLK_PERIOD_NS)

`endif

// file: hdl/drp_pkg.sv
package drp_pkg;

   // command word written to the control register, bit 0 last
   typedef struct packed {
      logic rate_ack;
      logic write_set;
      logic write_clr;
      logic test_clr;
      logic test_set;
      logic clear;
      logic start;
   } drp_cmd_type;

   // status word sampled into the input latch, bit 0 last
   typedef struct packed {
      logic load_avail;
      logic rate_error;
      logic crc_error;
      logic fifo_avail;
      logic read_active;
      logic loopback;
      logic started;
   } drp_status_type;

   // read sequencer states
   typedef enum logic [1:0] {
      DRP_SEQ_IDLE,
      DRP_SEQ_HUNT,
      DRP_SEQ_READ
   } drp_seq_type;

endpackage

// file: hdl/drp_test_clock.sv
`timescale 1ns/1ps
`include "drp_params.svh"

module drp_test_clock
   import drp_pkg::*;
#(
   parameter int PHASE_CYC = `DRP_TEST_PHASE_CYC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic enable,
   input wire logic load,
   input wire logic [15:0] load_count,
   output logic selftest_clock_n,
   output logic test_tick,
   output logic [15:0] pulses_left
);

   logic [7:0] phase_cnt;
   logic phase_end;

   assign phase_end = (phase_cnt == 8'(PHASE_CYC - 1));
   // one cycle at the end of each low (active) phase
   assign test_tick = phase_end && !selftest_clock_n;

   // ****************************************
   // phase timer and pulse counter
   // ****************************************
   // high phase then low phase, each PHASE_CYC cycles
   always_ff @(posedge clk) begin
      if (!reset_n || !enable) begin
         phase_cnt <= 8'h00;
         selftest_clock_n <= 1'b1;
      end else if (pulses_left != 16'h0000 || !selftest_clock_n) begin
         if (phase_end) begin
            phase_cnt <= 8'h00;
            selftest_clock_n <= ~selftest_clock_n;
         end else begin
            phase_cnt <= phase_cnt + 8'h01;
         end
      end
   end

   // pulses still to be generated
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pulses_left <= 16'h0000;
      end else if (load) begin
         pulses_left <= load_count;
      end else if (enable && phase_end && selftest_clock_n && pulses_left != 16'h0000) begin
         pulses_left <= pulses_left - 16'h0001;
      end
   end

endmodule

// file: hdl/drp_fifo.sv
`timescale 1ns/1ps
`include "drp_params.svh"

module drp_fifo
   import drp_pkg::*;
#(
   parameter int WIDTH = `DRP_WORD_BITS,
   parameter int DEPTH = `DRP_FIFO_DEPTH,
   parameter int SLICE_W = `DRP_SLICE_W,
   parameter int SLICES = WIDTH / SLICE_W
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic flush,
   input wire logic push,
   input wire logic [WIDTH-1:0] push_data,
   input wire logic pop,
   output logic [WIDTH-1:0] pop_data,
   output logic fifo_input_ready_n,
   output logic [SLICES-1:0] fifo_output_ready_flags
);

   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH + 1);

   logic [SLICES-1:0] slice_full;

   // any full slice refuses the next word
   assign fifo_input_ready_n = |slice_full;

   // ****************************************
   // one storage slice per device
   // ****************************************
   genvar s;
   generate
      for (s = 0; s < SLICES; s = s + 1) begin : g_slice
         logic [SLICE_W-1:0] mem [DEPTH];
         logic [PTR_W-1:0] wr_ptr;
         logic [PTR_W-1:0] rd_ptr;
         logic [CNT_W-1:0] count;
         logic do_push;
         logic do_pop;

         assign slice_full[s] = (count == CNT_W'(DEPTH));
         assign fifo_output_ready_flags[s] = (count != '0);
         assign do_push = push && !slice_full[s];
         assign do_pop = pop && (count != '0);
         assign pop_data[s*SLICE_W +: SLICE_W] = mem[rd_ptr];

         // pointers and fill level, flushed by a path clear
         always_ff @(posedge clk) begin
            if (!reset_n || flush) begin
               wr_ptr <= '0;
               rd_ptr <= '0;
               count <= '0;
            end else begin
               if (do_push) begin
                  wr_ptr <= PTR_W'(wr_ptr + 1'b1);
               end
               if (do_pop) begin
                  rd_ptr <= PTR_W'(rd_ptr + 1'b1);
               end
               count <= CNT_W'(count + CNT_W'(do_push) - CNT_W'(do_pop));
            end
         end

         // storage
         always_ff @(posedge clk) begin
            if (do_push) begin
               mem[wr_ptr] <= push_data[s*SLICE_W +: SLICE_W];
            end
         end
      end
   endgenerate

endmodule

// file: hdl/drp_read_path.sv
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "drp_params.svh"

module drp_read_path
   import drp_pkg::*;
#(
   parameter int WORD_W = `DRP_WORD_BITS,
   parameter int FIFO_DEPTH = `DRP_FIFO_DEPTH,
   parameter int SLICE_W = `DRP_SLICE_W
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [`DRP_ADDR_W-1:0] address,
   input wire logic [`DRP_DATA_W-1:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   output logic [`DRP_DATA_W-1:0] read_data,
   input wire logic external_bit_clock_n,
   input wire logic external_read_data,
   output logic disk_interface_activate,
   output logic read_active_n,
   output logic selftest_clock_n,
   output logic fifo_load_pulse
);

   localparam int SLICES = WORD_W / SLICE_W;

   // ****************************************
   // declarations
   // ****************************************
   drp_cmd_type cmd;
   drp_status_type status_now;
   drp_status_type status_latch;
   drp_seq_type state;
   logic cmd_wr;
   logic path_clear_n;
   logic start_latch_preset_n;
   logic start_latch_clock_n;
   logic start_request_latched;
   logic synced_start_flag;
   logic loopback_mode_flag;
   logic write_mode;
   logic ext_clk_meta;
   logic ext_clk_sync;
   logic ext_data_meta;
   logic ext_data_sync;
   logic bit_clock_n;
   logic bit_clock_prev;
   logic bit_event;
   logic serial_in;
   logic loopback_serial_bit;
   logic [WORD_W-1:0] shift_reg;
   logic [WORD_W-1:0] next_shift;
   logic [3:0] bit_count;
   logic bit_count_terminal;
   logic sync_pattern_decode;
   logic sync_found_latch_n;
   logic [15:0] crc_reg;
   logic [15:0] next_crc;
   logic crc_ok;
   logic overrun_error_latch;
   logic fifo_input_ready_n;
   logic [SLICES-1:0] fifo_output_ready_flags;
   logic fifo_avail;
   logic fifo_pop;
   logic [WORD_W-1:0] fifo_head;
   logic [WORD_W-1:0] test_word;
   logic test_tick;
   logic test_pulse_load;
   logic [15:0] pulses_left;

   // ****************************************
   // command decode
   // ****************************************
   // each write to the control register issues one-cycle commands
   assign cmd_wr = write_strobe && (address == `DRP_OFS_CTRL);
   assign cmd = drp_cmd_type'(write_data[`DRP_CMD_W-1:0]);
   assign path_clear_n = ~(cmd_wr && cmd.clear);
   assign start_latch_preset_n = path_clear_n;
   assign start_latch_clock_n = ~(cmd_wr && cmd.start);
   assign test_pulse_load = write_strobe && (address == `DRP_OFS_TEST_PULSES);

   // ****************************************
   // pin synchronisers
   // ****************************************
   // two flops for the drive clock and drive data
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ext_clk_meta <= 1'b1;
         ext_clk_sync <= 1'b1;
         ext_data_meta <= 1'b0;
         ext_data_sync <= 1'b0;
      end else begin
         ext_clk_meta <= external_bit_clock_n;
         ext_clk_sync <= ext_clk_meta;
         ext_data_meta <= external_read_data;
         ext_data_sync <= ext_data_meta;
      end
   end

   // ****************************************
   // bit clock selection and edge detect
   // ****************************************
   // drive clock forced high in test, test clock gated in
   assign bit_clock_n = (ext_clk_sync | loopback_mode_flag) & selftest_clock_n;
   assign bit_event = bit_clock_prev && !bit_clock_n;
   assign serial_in = loopback_mode_flag ? loopback_serial_bit : ext_data_sync;

   // previous bit clock level
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         bit_clock_prev <= 1'b1;
      end else begin
         bit_clock_prev <= bit_clock_n;
      end
   end

   // ****************************************
   // mode flags
   // ****************************************
   // test mode held until explicitly cleared
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         loopback_mode_flag <= 1'b0;
      end else if (cmd_wr && cmd.test_set) begin
         loopback_mode_flag <= 1'b1;
      end else if (cmd_wr && cmd.test_clr) begin
         loopback_mode_flag <= 1'b0;
      end
   end

   // write mode; clearing write logic leaves read mode
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         write_mode <= 1'b0;
      end else if (cmd_wr && cmd.write_clr) begin
         write_mode <= 1'b0;
      end else if (cmd_wr && cmd.write_set) begin
         write_mode <= 1'b1;
      end
   end

   // ****************************************
   // start latch and its synchroniser
   // ****************************************
   // start latch, preset input overrides the clock
   always_ff @(posedge clk) begin
      if (!reset_n || !start_latch_preset_n) begin
         start_request_latched <= 1'b0;
      end else if (!start_latch_clock_n) begin
         start_request_latched <= 1'b1;
      end
   end

   // second stage loads only on a bit clock edge, path clear resets it
   always_ff @(posedge clk) begin
      if (!reset_n || !path_clear_n) begin
         synced_start_flag <= 1'b0;
      end else if (bit_event) begin
         synced_start_flag <= start_request_latched;
      end
   end

   assign disk_interface_activate = synced_start_flag;

   // ****************************************
   // loopback test register
   // ****************************************
   // loaded by software, rotated once per test clock pulse
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         test_word <= `DRP_TEST_WORD_RESET;
      end else if (write_strobe && address == `DRP_OFS_TEST_WORD) begin
         test_word <= write_data[WORD_W-1:0];
      end else if (test_tick) begin
         test_word <= {test_word[WORD_W-2:0], test_word[WORD_W-1]};
      end
   end

   assign loopback_serial_bit = test_word[WORD_W-1];

   drp_test_clock u_test_clock (
      .clk(clk),
      .reset_n(reset_n),
      .enable(loopback_mode_flag),
      .load(test_pulse_load),
      .load_count(write_data[15:0]),
      .selftest_clock_n(selftest_clock_n),
      .test_tick(test_tick),
      .pulses_left(pulses_left)
   );

   // ****************************************
   // deserializer and sequencer
   // ****************************************
   assign next_shift = {shift_reg[WORD_W-2:0], serial_in};
   assign sync_pattern_decode = (next_shift == `DRP_SYNC_WORD);
   assign bit_count_terminal = (state == DRP_SEQ_READ) && (bit_count == 4'hF);
   // word completes only while reading, never the sync word
   assign fifo_load_pulse = bit_event && bit_count_terminal;
   assign read_active_n = (state != DRP_SEQ_READ);

   // serial to parallel shift
   always_ff @(posedge clk) begin
      if (!reset_n || !path_clear_n) begin
         shift_reg <= '0;
      end else if (bit_event && state != DRP_SEQ_IDLE) begin
         shift_reg <= next_shift;
      end
   end

   // sequencer: idle, hunt for sync, read words
   always_ff @(posedge clk) begin
      if (!reset_n || !path_clear_n) begin
         state <= DRP_SEQ_IDLE;
         sync_found_latch_n <= 1'b1;
      end else begin
         unique case (state)
            DRP_SEQ_IDLE: begin
               if (synced_start_flag && !write_mode) begin
                  state <= DRP_SEQ_HUNT;
               end
            end
            DRP_SEQ_HUNT: begin
               if (bit_event && sync_pattern_decode) begin
                  state <= DRP_SEQ_READ;
                  sync_found_latch_n <= 1'b0;
               end
            end
            DRP_SEQ_READ: begin
               state <= DRP_SEQ_READ;
            end
         endcase
      end
   end

   // bit counter restarts at the sync word
   always_ff @(posedge clk) begin
      if (!reset_n || !path_clear_n || state != DRP_SEQ_READ) begin
         bit_count <= 4'h0;
      end else if (bit_event) begin
         bit_count <= bit_count + 4'h1;
      end
   end

   // ****************************************
   // CRC checker
   // ****************************************
   always_comb begin
      next_crc = {crc_reg[14:0], 1'b0} ^ ((crc_reg[15] ^ serial_in) ? `DRP_CRC_POLY : 16'h0000);
   end

   // residue zero at a word boundary marks a good record end
   always_ff @(posedge clk) begin
      if (!reset_n || !path_clear_n || state != DRP_SEQ_READ) begin
         crc_reg <= `DRP_CRC_INIT;
         crc_ok <= 1'b0;
      end else if (bit_event) begin
         crc_reg <= next_crc;
         crc_ok <= bit_count_terminal && (next_crc == 16'h0000);
      end
   end

   // ****************************************
   // FIFO and rate error
   // ****************************************
   // word available only when every device has one
   assign fifo_avail = &fifo_output_ready_flags;
   assign fifo_pop = read_strobe && (address == `DRP_OFS_FIFO_DATA) && fifo_avail;

   drp_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH),
      .SLICE_W(SLICE_W)
   ) u_fifo (
      .clk(clk),
      .reset_n(reset_n),
      .flush(!path_clear_n),
      .push(fifo_load_pulse && !fifo_input_ready_n),
      .push_data(next_shift),
      .pop(fifo_pop),
      .pop_data(fifo_head),
      .fifo_input_ready_n(fifo_input_ready_n),
      .fifo_output_ready_flags(fifo_output_ready_flags)
   );

   // load into a full FIFO is a rate error; set beats acknowledge
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         overrun_error_latch <= 1'b0;
      end else if (fifo_load_pulse && fifo_input_ready_n) begin
         overrun_error_latch <= 1'b1;
      end else if (cmd_wr && cmd.rate_ack) begin
         overrun_error_latch <= 1'b0;
      end
   end

   // ****************************************
   // status input latch and read port
   // ****************************************
   always_comb begin
      status_now.started = synced_start_flag;
      status_now.loopback = loopback_mode_flag;
      status_now.read_active = !sync_found_latch_n;
      status_now.fifo_avail = fifo_avail;
      status_now.crc_error = !crc_ok;
      status_now.rate_error = overrun_error_latch;
      status_now.load_avail = !fifo_input_ready_n;
   end

   // all flags sampled together every cycle
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         status_latch <= '0;
      end else begin
         status_latch <= status_now;
      end
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (!reset_n || !read_strobe) begin
         read_data <= '0;
      end else begin
         unique case (address)
            `DRP_OFS_STATUS: read_data <= `DRP_DATA_W'(status_latch);
            `DRP_OFS_FIFO_DATA: read_data <= fifo_avail ? `DRP_DATA_W'(fifo_head) : '0;
            `DRP_OFS_TEST_WORD: read_data <= `DRP_DATA_W'(test_word);
            `DRP_OFS_TEST_PULSES: read_data <= pulses_left;
            default: read_data <= '0;
         endcase
      end
   end

endmodule

// file: tb/drp_read_path_properties.sv
`timescale 1ns/1ps
`include "drp_params.svh"

// ****
// port checker
// ****
module drp_read_path_properties
   import drp_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [`DRP_ADDR_W-1:0] address,
   input wire logic [`DRP_DATA_W-1:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   input wire logic [`DRP_DATA_W-1:0] read_data,
   input wire logic external_bit_clock_n,
   input wire logic disk_interface_activate,
   input wire logic read_active_n,
   input wire logic selftest_clock_n,
   input wire logic fifo_load_pulse
);
   localparam int PHASE_LAST = `DRP_TEST_PHASE_CYC - 1;
   logic tst_q;
   logic ext_q;
   logic [7:0] run_len;
   logic [7:0] fall_age;

   // length of the present test clock level
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tst_q <= 1'b1;
         run_len <= 8'h00;
      end else begin
         tst_q <= selftest_clock_n;
         if (selftest_clock_n != tst_q) begin
            run_len <= 8'h00;
         end else if (run_len != 8'hFF) begin
            run_len <= run_len + 8'h01;
         end
      end
   end

   // cycles since either bit clock source fell
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ext_q <= 1'b1;
         fall_age <= 8'hFF;
      end else begin
         ext_q <= external_bit_clock_n;
         if ((tst_q && !selftest_clock_n) || (ext_q && !external_bit_clock_n)) begin
            fall_age <= 8'h00;
         end else if (fall_age != 8'hFF) begin
            fall_age <= fall_age + 8'h01;
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_read_idle_zero: assert property (!$past(read_strobe) |-> read_data == 16'h0000)
      else $error("read data not zero outside answer");
   a_clear_stops_path: assert property (
      write_strobe && address == `DRP_OFS_CTRL && write_data[`DRP_CMD_CLEAR] && !write_data[`DRP_CMD_START]
      |=> !disk_interface_activate && read_active_n && !fifo_load_pulse)
      else $error("path clear left sequencing on");
   a_load_in_read: assert property (fifo_load_pulse |-> !read_active_n)
      else $error("load outside read state");
   a_load_spacing: assert property (fifo_load_pulse |=> !fifo_load_pulse [*8])
      else $error("loads too close");
   a_load_on_edge: assert property (fifo_load_pulse |=> fall_age <= 8'h06)
      else $error("load not at bit edge");
   a_start_on_edge: assert property ($rose(disk_interface_activate) |-> fall_age <= 8'h06)
      else $error("start flag not at bit edge");
   a_test_low_phase: assert property ($rose(selftest_clock_n) |-> run_len == PHASE_LAST)
      else $error("test clock low phase wrong");
   a_test_high_phase: assert property ($fell(selftest_clock_n) |-> run_len >= PHASE_LAST)
      else $error("test clock high phase short");
   a_read_needs_start: assert property (!read_active_n |-> disk_interface_activate)
      else $error("read active without start");

   cover property (fifo_load_pulse);
   cover property ($rose(disk_interface_activate));
   cover property ($rose(selftest_clock_n));
endmodule

bind drp_read_path drp_read_path_properties i_props (.clk(clk), .reset_n(reset_n), .address(address),
   .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
   .external_bit_clock_n(external_bit_clock_n), .disk_interface_activate(disk_interface_activate),
   .read_active_n(read_active_n), .selftest_clock_n(selftest_clock_n), .fifo_load_pulse(fifo_load_pulse));

// file: tb/drp_disk_model.sv
`timescale 1ns/1ps

// ****
// drive read channel
// ****
module drp_disk_model (
   output logic bit_clock_n,
   output logic serial_data
);
   // clock stands high outside frames
   initial begin
      bit_clock_n = 1'b1;
      serial_data = 1'b0;
   end

   // msb first, 160 ns per bit, then data line inverted
   task automatic send(input logic [15:0] w, input int n);
      #3;
      for (int i = n - 1; i >= 0; i--) begin
         serial_data = w[i];
         #40;
         bit_clock_n = 1'b0;
         #80;
         bit_clock_n = 1'b1;
         #40;
      end
      serial_data = ~serial_data;
   endtask
endmodule

// file: tb/tb_drp_read_path.sv
`timescale 1ns/1ps
`include "drp_params.svh"

module tb_drp_read_path
   import drp_pkg::*;
;
   logic clk;
   logic reset_n;
   logic [7:0] address;
   logic [15:0] write_data;
   logic write_strobe;
   logic read_strobe;
   logic [15:0] read_data;
   logic ext_clk_n;
   logic ext_data;
   logic activate;
   logic read_active_n;
   logic test_clk_n;
   logic load_pulse;
   logic [15:0] v;
   logic [15:0] crc;
   int fail_count;
   int comparisons;
   int loads = 0;
   int base;

   // 50 MHz clock
   initial clk = 1'b0;
   always #10 clk = ~clk;

   drp_read_path i_dut (.clk(clk), .reset_n(reset_n), .address(address), .write_data(write_data),
      .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
      .external_bit_clock_n(ext_clk_n), .external_read_data(ext_data), .disk_interface_activate(activate),
      .read_active_n(read_active_n), .selftest_clock_n(test_clk_n), .fifo_load_pulse(load_pulse));
   drp_disk_model i_disk (.bit_clock_n(ext_clk_n), .serial_data(ext_data));

   // count word loads seen on the pin
   always @(posedge clk) begin
      if (load_pulse === 1'b1) begin
         loads++;
      end
   end

   // ****
   // tasks
   // ****
   task automatic finish_test();
      $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      address <= a;
      write_data <= d;
      write_strobe <= 1'b1;
      @(posedge clk);
      write_strobe <= 1'b0;
   endtask

   // read after status latch settles, compare masked value
   task automatic rchk(input logic [7:0] a, input logic [15:0] exp, input logic [15:0] mask);
      repeat (2) @(posedge clk);
      address <= a;
      read_strobe <= 1'b1;
      @(posedge clk);
      read_strobe <= 1'b0;
      @(negedge clk);
      chk(read_data & mask, exp);
   endtask

   // emit test clock pulses, wait until none remain
   task automatic pulses(input logic [15:0] n);
      wr(`DRP_OFS_TEST_PULSES, n);
      v = 16'hFFFF;
      for (int i = 0; i < 10000 && v !== 16'h0000; i++) begin
         @(posedge clk);
         address <= `DRP_OFS_TEST_PULSES;
         read_strobe <= 1'b1;
         @(posedge clk);
         read_strobe <= 1'b0;
         @(negedge clk);
         v = read_data;
      end
      chk(v, 16'h0000);
      if (v !== 16'h0000) finish_test();
      repeat (40) @(posedge clk);
   endtask

   function automatic logic [15:0] crc_word(input logic [15:0] w);
      logic [15:0] c;
      c = `DRP_CRC_INIT;
      for (int i = 15; i >= 0; i--) begin
         if (c[15] ^ w[i]) c = {c[14:0], 1'b0} ^ `DRP_CRC_POLY;
         else c = {c[14:0], 1'b0};
      end
      return c;
   endfunction

   // ****
   // main sequence
   // ****
   initial begin
      reset_n = 1'b0;
      address = 8'h00;
      write_data = 16'h0000;
      write_strobe = 1'b0;
      read_strobe = 1'b0;
      fail_count = 0;
      comparisons = 0;
      crc = crc_word(16'hA5C3);
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      rchk(`DRP_OFS_STATUS, 16'h0050, 16'hFFFF);
      rchk(8'h14, 16'h0000, 16'hFFFF);
      wr(`DRP_OFS_CTRL, 16'h0016);
      rchk(`DRP_OFS_STATUS, 16'h0052, 16'hFFFF);
      rchk(`DRP_OFS_TEST_WORD, 16'h0000, 16'hFFFF);
      wr(`DRP_OFS_TEST_WORD, 16'h00FF);
      pulses(16'h0021);
      rchk(`DRP_OFS_STATUS, 16'h0052, 16'hFFFF);
      chk(loads[15:0], 16'h0000);
      rchk(`DRP_OFS_TEST_WORD, 16'h01FE, 16'hFFFF);
      wr(`DRP_OFS_CTRL, 16'h0001);
      i_disk.send(16'hFFFF, 16);
      rchk(`DRP_OFS_STATUS, 16'h0052, 16'hFFFF);
      pulses(16'h0040);
      rchk(`DRP_OFS_STATUS, 16'h004F, 16'h006F);
      chk({15'h0000, activate}, 16'h0001);
      chk({15'h0000, read_active_n}, 16'h0000);
      rchk(`DRP_OFS_FIFO_DATA, 16'h00FF, 16'hFFFF);
      wr(`DRP_OFS_CTRL, 16'h0002);
      rchk(`DRP_OFS_STATUS, 16'h0052, 16'hFFFF);
      chk({15'h0000, read_active_n}, 16'h0001);
      // overfill, acknowledge, drain
      wr(`DRP_OFS_CTRL, 16'h0001);
      pulses(16'h0140);
      rchk(`DRP_OFS_STATUS, 16'h0028, 16'h0068);
      wr(`DRP_OFS_CTRL, 16'h0040);
      rchk(`DRP_OFS_STATUS, 16'h0000, 16'h0020);
      for (int i = 0; i < 16; i++) begin
         rchk(`DRP_OFS_FIFO_DATA, 16'h00FF, 16'hFFFF);
      end
      rchk(`DRP_OFS_STATUS, 16'h0040, 16'h0048);
      // drive data with appended check word
      wr(`DRP_OFS_CTRL, 16'h001A);
      wr(`DRP_OFS_CTRL, 16'h0001);
      base = loads;
      i_disk.send(16'h0000, 4);
      i_disk.send(`DRP_SYNC_WORD, 16);
      i_disk.send(16'hA5C3, 16);
      i_disk.send(crc, 16);
      repeat (20) @(posedge clk);
      chk(16'(loads - base), 16'h0002);
      rchk(`DRP_OFS_STATUS, 16'h000C, 16'h001C);
      rchk(`DRP_OFS_FIFO_DATA, 16'hA5C3, 16'hFFFF);
      rchk(`DRP_OFS_FIFO_DATA, crc, 16'hFFFF);
      // write mode keeps the sequencer out of the hunt
      wr(`DRP_OFS_CTRL, 16'h0022);
      wr(`DRP_OFS_CTRL, 16'h0001);
      i_disk.send(`DRP_SYNC_WORD, 16);
      i_disk.send(`DRP_SYNC_WORD, 16);
      rchk(`DRP_OFS_STATUS, 16'h0001, 16'h000D);
      chk({15'h0000, read_active_n}, 16'h0001);
      finish_test();
   end
endmodule
